// [src/link_mode_pkg.sv]
// Constants, offsets and types for the link mode and error status block
package link_mode_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SILENCE_NS    = 10000;
  localparam int          SILENCE_CYC   = SILENCE_NS / CLK_PERIOD_NS;
  localparam int          CNT_W         = 16;
  localparam logic [15:0] ACQ_GOOD_CNT  = 16'h0004;
  localparam logic [15:0] LOSS_BAD_CNT  = 16'h0004;
  localparam int          PIN_W         = 14;
  localparam int          MODE_W        = 13;

  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_MASK     = 8'h04;
  localparam logic [7:0]  ADDR_STATE    = 8'h08;
  localparam logic [7:0]  ADDR_CTRL     = 8'h0C;

  localparam int          ST_W          = 4;
  localparam int          ST_CODE_ERR   = 0;
  localparam int          ST_SYNC_LOST  = 1;
  localparam int          ST_SYNC_GAIN  = 2;
  localparam int          ST_MODE_CHG   = 3;
  localparam logic [3:0]  STATUS_RST    = 4'h0;
  localparam logic [3:0]  MASK_RST      = 4'h0;

  localparam int          SF_LOS        = 0;
  localparam int          SF_SYNCED     = 1;
  localparam int          SF_CODE_ERROR_LATCH       = 2;
  localparam int          SF_MODE_LSB   = 3;
  localparam int          SF_PORN       = 16;

  localparam int          CTRL_RESYNC   = 0;
  localparam int          CTRL_HOLD     = 1;
  localparam logic        CTRL_HOLD_RST = 1'b0;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    SYNC_HUNT    = 2'h0,
    SYNC_ACQUIRE = 2'h1,
    SYNC_LOCKED  = 2'h3
  } sync_state_t;
endpackage

// [src/pin_sync.sv]
// Three-stage synchroniser for strapped pins, updating once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,     // System clock
  input  wire logic         aresetn,  // Synchronous reset, active low
  input  wire logic [W-1:0] pin_in,   // Asynchronous pin levels
  input  wire logic [W-1:0] rst_val,  // Constant value after reset
  output logic      [W-1:0] pin_out   // Qualified synchronised levels
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_nxt;

  always_comb
  begin
    out_nxt = pin_out;
    for (int i = 0; i < W; i++)
    begin
      if (s2_r[i] == s3_r[i])
        out_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r    <= rst_val;
      s2_r    <= rst_val;
      s3_r    <= rst_val;
      pin_out <= rst_val;
    end
    else
    begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      pin_out <= out_nxt;
    end
  end
endmodule

// [src/code_checker.sv]
// Checks received ten-bit code groups against the sub-block disparity rules
`timescale 1ns/1ps
module code_checker (
  input  wire logic       aclk,       // System clock
  input  wire logic       aresetn,    // Synchronous reset, active low
  input  wire logic       enable,     // Checking active while link not hunting
  input  wire logic [9:0] code,       // Received code group
  input  wire logic       code_valid, // Code group present this cycle
  output logic            err_r,      // One-cycle pulse per violation
  output logic            done_r      // One-cycle pulse per checked group
);
  logic rd_r;
  logic rd_known_r;
  logic rd_nxt;
  logic rd_known_nxt;
  logic err_nxt;
  logic done_nxt;
  logic [2:0] ones6;
  logic [2:0] ones4;

  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++)
      n = n + {2'h0, v[i]};
    return n;
  endfunction

  always_comb
  begin
    ones6        = ones(code[9:4]);
    ones4        = ones({2'h0, code[3:0]});
    rd_nxt       = rd_r;
    rd_known_nxt = rd_known_r;
    err_nxt      = 1'b0;
    done_nxt     = 1'b0;
    if (!enable)
    begin
      rd_nxt       = 1'b0;
      rd_known_nxt = 1'b0;
    end
    else if (code_valid)
    begin
      done_nxt = 1'b1;
      // Sub-block weight out of range, or unbalanced the wrong way
      if (ones6 < 3'h2 || ones6 > 3'h4 || ones4 < 3'h1 || ones4 > 3'h3)
        err_nxt = 1'b1;
      else
      begin
        if (ones6 != 3'h3)
        begin
          if (rd_known_r && ((ones6 == 3'h4) == rd_r))
            err_nxt = 1'b1;
          rd_nxt = (ones6 == 3'h4);
        end
        if (ones4 != 3'h2)
        begin
          if ((rd_known_r || ones6 != 3'h3) && ((ones4 == 3'h3) == rd_nxt))
            err_nxt = 1'b1;
          rd_nxt = (ones4 == 3'h3);
        end
        if (ones6 != 3'h3 || ones4 != 3'h2)
          rd_known_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_r       <= 1'b0;
      rd_known_r <= 1'b0;
      err_r      <= 1'b0;
      done_r     <= 1'b0;
    end
    else
    begin
      rd_r       <= rd_nxt;
      rd_known_r <= rd_known_nxt;
      err_r      <= err_nxt;
      done_r     <= done_nxt;
    end
  end
endmodule

// [src/link_mode_and_error_status.sv]
// Mode straps, link sync state, code error flags and AXI4-Lite register file
//
// Behaviour
// - Format hold low selects asymmetrical mode, high selects symmetrical mode.
// - Laser set-up low selects power adjustment mode, high normal operation.
// - Three-bit diagnostic select picks normal, local or remote loopback modes.
// - Two-bit line format select picks NRZ, HDB3, B8ZS or AMI interpretation.
// - Loss-of-signal output high while receive data unreliable, low when reliable.
// - Code-error latch goes high on any 8B10B violation received while the link is not hunting, and stays high.
// - Code-error latch clears whenever link forced out of sync, including reset, unless a violation sets it in the same cycle.
// - Error pulse output goes high with each individual 8B10B violation received while the link is not hunting.
// - Four-bit rate select sets line rate and number of main channels.
// - Power-on reset input low initialises; high needed for normal operation.
// - Carrier detect high only when modems synchronised and exchanging data.
`timescale 1ns/1ps
module link_mode_and_error_status (
  input  wire logic        aclk,               // System clock
  input  wire logic        aresetn,            // Synchronous reset, active low
  input  wire logic        format_hold,        // High symmetrical, low asymmetrical
  input  wire logic        laser_setup_n,      // Low selects laser power adjustment
  input  wire logic        diag_mode_sel_0,    // Diagnostic mode select bit 0
  input  wire logic        diag_mode_sel_1,    // Diagnostic mode select bit 1
  input  wire logic        diag_mode_sel_2,    // Diagnostic mode select bit 2
  input  wire logic        line_format_sel_0,  // Line format select bit 0
  input  wire logic        line_format_sel_1,  // Line format select bit 1
  input  wire logic        rate_sel_0,         // Data rate select bit 0
  input  wire logic        rate_sel_1,         // Data rate select bit 1
  input  wire logic        rate_sel_2,         // Data rate select bit 2
  input  wire logic        rate_sel_3,         // Data rate select bit 3
  input  wire logic        power_on_reset_n,   // Power-on reset pin, active low
  input  wire logic [9:0]  rx_code,            // Received 8B10B code group
  input  wire logic        rx_code_valid,      // Code group strobe
  output logic             signal_missing_flag,// Receive data unreliable
  output logic             link_synced_flag,   // Modems synchronised
  output logic             code_error_latch,   // Sticky code error
  output logic             code_error_pulse,   // One pulse per code error
  output logic             symmetric_mode,     // Applied format hold
  output logic             laser_adjust_mode,  // Applied laser set-up mode
  output logic [2:0]       diag_mode,          // Applied diagnostic mode
  output logic [1:0]       line_format,        // Applied line format
  output logic [3:0]       active_rate,        // Applied data rate select
  output logic             irq,                // Level interrupt
  input  wire logic [7:0]  s_axi_awaddr,       // Write address
  input  wire logic        s_axi_awvalid,      // Write address valid
  output logic             s_axi_awready,      // Write address ready
  input  wire logic [31:0] s_axi_wdata,        // Write data
  input  wire logic [3:0]  s_axi_wstrb,        // Write byte strobes
  input  wire logic        s_axi_wvalid,       // Write data valid
  output logic             s_axi_wready,       // Write data ready
  output logic [1:0]       s_axi_bresp,        // Write response
  output logic             s_axi_bvalid,       // Write response valid
  input  wire logic        s_axi_bready,       // Write response ready
  input  wire logic [7:0]  s_axi_araddr,       // Read address
  input  wire logic        s_axi_arvalid,      // Read address valid
  output logic             s_axi_arready,      // Read address ready
  output logic [31:0]      s_axi_rdata,        // Read data
  output logic [1:0]       s_axi_rresp,        // Read response
  output logic             s_axi_rvalid,       // Read data valid
  input  wire logic        s_axi_rready        // Read data ready
);
  localparam int MW = link_mode_pkg::MODE_W;
  localparam int SW = link_mode_pkg::ST_W;
  localparam logic [15:0] SIL_CNT = 16'(link_mode_pkg::SILENCE_CYC);

  logic [link_mode_pkg::PIN_W-1:0] pins_raw;
  logic [link_mode_pkg::PIN_W-1:0] pins_sync;
  logic [link_mode_pkg::PIN_W-1:0] pins_rst;
  logic                            por_ok;
  logic                            chk_err;
  logic                            chk_done;

  // Pin word: {por_n, 0, rate[3:0], format[1:0], diag[2:0], 0, setup_n, fhold}
  assign pins_raw = {power_on_reset_n, 1'b0, rate_sel_3, rate_sel_2, rate_sel_1, rate_sel_0,
                     line_format_sel_1, line_format_sel_0, diag_mode_sel_2, diag_mode_sel_1,
                     diag_mode_sel_0, 1'b0, laser_setup_n, format_hold};
  assign pins_rst = {1'b0, 10'h000, 1'b0, 1'b1, 1'b1};

  pin_sync #(.W(link_mode_pkg::PIN_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (pins_raw),
    .rst_val (pins_rst),
    .pin_out (pins_sync)
  );

  logic [MW-1:0] mode_now;
  assign mode_now = {pins_sync[12:0]};
  assign por_ok   = pins_sync[13];

  // Sync state and mode application
  link_mode_pkg::sync_state_t state_r;
  link_mode_pkg::sync_state_t state_nxt;
  logic [15:0]   good_r;
  logic [15:0]   good_nxt;
  logic [15:0]   bad_r;
  logic [15:0]   bad_nxt;
  logic [15:0]   quiet_r;
  logic [15:0]   quiet_nxt;
  logic [MW-1:0] mode_r;
  logic [MW-1:0] mode_nxt;
  logic          force_out;
  logic          mode_diff;
  logic          resync_r;
  logic          hold_r;
  logic          code_error_latch_nxt;
  logic          chk_en;

  assign chk_en = (state_r != link_mode_pkg::SYNC_HUNT);

  code_checker u_chk (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (chk_en),
    .code       (rx_code),
    .code_valid (rx_code_valid),
    .err_r      (chk_err),
    .done_r     (chk_done)
  );

  always_comb
  begin
    state_nxt = state_r;
    good_nxt  = good_r;
    bad_nxt   = bad_r;
    quiet_nxt = rx_code_valid ? 16'h0000 : quiet_r + 16'h0001;
    mode_nxt  = mode_r;
    mode_diff = (mode_now != mode_r);
    force_out = !por_ok || hold_r || resync_r || mode_diff;
    if (force_out)
    begin
      state_nxt = link_mode_pkg::SYNC_HUNT;
      mode_nxt  = mode_now;
      good_nxt  = 16'h0000;
      bad_nxt   = 16'h0000;
    end
    else
    begin
      case (state_r)
        link_mode_pkg::SYNC_HUNT:
        begin
          good_nxt = 16'h0000;
          bad_nxt  = 16'h0000;
          if (rx_code_valid)
            state_nxt = link_mode_pkg::SYNC_ACQUIRE;
        end
        link_mode_pkg::SYNC_ACQUIRE:
        begin
          if (chk_done && chk_err)
            state_nxt = link_mode_pkg::SYNC_HUNT;
          else if (chk_done)
          begin
            good_nxt = good_r + 16'h0001;
            if (good_nxt >= link_mode_pkg::ACQ_GOOD_CNT)
              state_nxt = link_mode_pkg::SYNC_LOCKED;
          end
          if (quiet_r >= SIL_CNT)
            state_nxt = link_mode_pkg::SYNC_HUNT;
        end
        link_mode_pkg::SYNC_LOCKED:
        begin
          if (chk_done && chk_err)
          begin
            bad_nxt = bad_r + 16'h0001;
            if (bad_nxt >= link_mode_pkg::LOSS_BAD_CNT)
              state_nxt = link_mode_pkg::SYNC_HUNT;
          end
          else if (chk_done)
            bad_nxt = 16'h0000;
          if (quiet_r >= SIL_CNT)
            state_nxt = link_mode_pkg::SYNC_HUNT;
        end
        default:
          state_nxt = link_mode_pkg::SYNC_HUNT;
      endcase
    end
    if (quiet_r == 16'hFFFF && !rx_code_valid)
      quiet_nxt = quiet_r;
    // Set wins over the out-of-sync clear
    code_error_latch_nxt = code_error_latch;
    if (state_r != link_mode_pkg::SYNC_HUNT && state_nxt == link_mode_pkg::SYNC_HUNT)
      code_error_latch_nxt = 1'b0;
    if (force_out)
      code_error_latch_nxt = 1'b0;
    if (chk_err && por_ok)
      code_error_latch_nxt = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r             <= link_mode_pkg::SYNC_HUNT;
      good_r              <= 16'h0000;
      bad_r               <= 16'h0000;
      quiet_r             <= 16'h0000;
      mode_r              <= 13'h0003;
      code_error_latch    <= 1'b0;
      code_error_pulse    <= 1'b0;
      signal_missing_flag <= 1'b1;
      link_synced_flag    <= 1'b0;
      symmetric_mode      <= 1'b1;
      laser_adjust_mode   <= 1'b0;
      diag_mode           <= 3'h0;
      line_format         <= 2'h0;
      active_rate         <= 4'h0;
    end
    else
    begin
      state_r             <= state_nxt;
      good_r              <= good_nxt;
      bad_r               <= bad_nxt;
      quiet_r             <= quiet_nxt;
      mode_r              <= mode_nxt;
      code_error_latch    <= code_error_latch_nxt;
      code_error_pulse    <= chk_err && por_ok;
      signal_missing_flag <= (state_nxt != link_mode_pkg::SYNC_LOCKED);
      link_synced_flag    <= (state_nxt == link_mode_pkg::SYNC_LOCKED);
      symmetric_mode      <= mode_nxt[0];
      laser_adjust_mode   <= !mode_nxt[1];
      diag_mode           <= mode_nxt[5:3];
      line_format         <= mode_nxt[7:6];
      active_rate         <= mode_nxt[11:8];
    end
  end

  // Register file and AXI4-Lite slave
  logic [SW-1:0] status_r;
  logic [SW-1:0] status_nxt;
  logic [SW-1:0] mask_r;
  logic [SW-1:0] mask_nxt;
  logic [SW-1:0] events;
  logic          hold_nxt;
  logic          resync_nxt;
  logic          aw_hold_r;
  logic          aw_hold_nxt;
  logic          w_hold_r;
  logic          w_hold_nxt;
  logic [7:0]    awaddr_r;
  logic [7:0]    awaddr_nxt;
  logic [31:0]   wdata_r;
  logic [31:0]   wdata_nxt;
  logic [3:0]    wstrb_r;
  logic [3:0]    wstrb_nxt;
  logic          bvalid_nxt;
  logic [1:0]    bresp_nxt;
  logic          rvalid_nxt;
  logic [31:0]   rdata_nxt;
  logic [1:0]    rresp_nxt;
  logic [31:0]   wmask;
  logic [31:0]   state_word;
  logic          do_write;

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == link_mode_pkg::ADDR_STATUS)
      return 3'h0;
    else if (a == link_mode_pkg::ADDR_MASK)
      return 3'h1;
    else if (a == link_mode_pkg::ADDR_STATE)
      return 3'h2;
    else if (a == link_mode_pkg::ADDR_CTRL)
      return 3'h3;
    else
      return 3'h4;
  endfunction

  always_comb
  begin
    events = '0;
    events[link_mode_pkg::ST_CODE_ERR]  = chk_err && por_ok;
    events[link_mode_pkg::ST_SYNC_LOST] = (state_r == link_mode_pkg::SYNC_LOCKED) &&
                                          (state_nxt != link_mode_pkg::SYNC_LOCKED);
    events[link_mode_pkg::ST_SYNC_GAIN] = (state_r != link_mode_pkg::SYNC_LOCKED) &&
                                          (state_nxt == link_mode_pkg::SYNC_LOCKED);
    events[link_mode_pkg::ST_MODE_CHG]  = mode_diff;
    state_word = '0;
    state_word[link_mode_pkg::SF_LOS]    = signal_missing_flag;
    state_word[link_mode_pkg::SF_SYNCED] = link_synced_flag;
    state_word[link_mode_pkg::SF_CODE_ERROR_LATCH]   = code_error_latch;
    state_word[link_mode_pkg::SF_MODE_LSB +: MW] = mode_r;
    state_word[link_mode_pkg::SF_PORN]   = por_ok;
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{wstrb_r[i]}};
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = s_axi_bvalid && !s_axi_bready;
    bresp_nxt   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    do_write   = aw_hold_r && w_hold_r && !s_axi_bvalid;
    status_nxt = status_r;
    mask_nxt   = mask_r;
    hold_nxt   = hold_r;
    resync_nxt = 1'b0;
    if (do_write)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = link_mode_pkg::RESP_OKAY;
      case (reg_sel(awaddr_r))
        3'h0: status_nxt = status_r & ~(wdata_r[SW-1:0] & wmask[SW-1:0]);
        3'h1: mask_nxt = (mask_r & ~wmask[SW-1:0]) | (wdata_r[SW-1:0] & wmask[SW-1:0]);
        3'h2: bresp_nxt = link_mode_pkg::RESP_OKAY;
        3'h3:
        begin
          if (wstrb_r[0])
          begin
            hold_nxt   = wdata_r[link_mode_pkg::CTRL_HOLD];
            resync_nxt = wdata_r[link_mode_pkg::CTRL_RESYNC];
          end
        end
        default: bresp_nxt = link_mode_pkg::RESP_SLVERR;
      endcase
    end
    status_nxt = status_nxt | events;
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = link_mode_pkg::RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        3'h0: rdata_nxt = {28'h0, status_r};
        3'h1: rdata_nxt = {28'h0, mask_r};
        3'h2: rdata_nxt = state_word;
        3'h3: rdata_nxt = {30'h0, hold_r, 1'b0};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = link_mode_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r      <= link_mode_pkg::STATUS_RST;
      mask_r        <= link_mode_pkg::MASK_RST;
      hold_r        <= link_mode_pkg::CTRL_HOLD_RST;
      resync_r      <= 1'b0;
      irq           <= 1'b0;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      status_r      <= status_nxt;
      mask_r        <= mask_nxt;
      hold_r        <= hold_nxt;
      resync_r      <= resync_nxt;
      irq           <= |(status_nxt & mask_nxt);
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_hold_nxt && !bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
    end
  end
endmodule

// [testbench/link_mode_monitor.sv]
// Checker for the link mode and error status block
`timescale 1ns/1ps
module link_mode_monitor (
  input wire logic aclk, aresetn, power_on_reset_n, rx_code_valid, irq, // Clock, reset, strobes
  input wire logic format_hold, laser_setup_n, symmetric_mode, laser_adjust_mode, // Straps
  input wire logic diag_mode_sel_0, diag_mode_sel_1, diag_mode_sel_2, // Diag pins
  input wire logic line_format_sel_0, line_format_sel_1, // Format pins
  input wire logic rate_sel_0, rate_sel_1, rate_sel_2, rate_sel_3, // Rate pins
  input wire logic signal_missing_flag, link_synced_flag, code_error_latch, code_error_pulse, // Flags
  input wire logic [2:0] diag_mode, // Applied diag
  input wire logic [1:0] line_format, // Applied format
  input wire logic [3:0] active_rate // Applied rate
);
  logic [10:0] pins, outs, quiet_r, quiet_nxt;
  assign pins = {format_hold, laser_setup_n, diag_mode_sel_2, diag_mode_sel_1, diag_mode_sel_0,
                 line_format_sel_1, line_format_sel_0, rate_sel_3, rate_sel_2, rate_sel_1, rate_sel_0};
  assign outs = {symmetric_mode, !laser_adjust_mode, diag_mode, line_format, active_rate};
  // Cycles since last code group, saturating
  always_comb quiet_nxt = rx_code_valid ? 11'h0 : quiet_r + {10'h0, quiet_r != 11'h7FF};
  always_ff @(posedge aclk) quiet_r <= aresetn ? quiet_nxt : 11'h0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_inv; signal_missing_flag != link_synced_flag; endproperty
  a_inv: assert property (p_inv) else $error("flags not inverse");
  property p_rst; $rose(aresetn) |-> signal_missing_flag && !code_error_latch && !code_error_pulse && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_por; !power_on_reset_n [*8] |-> signal_missing_flag && !code_error_latch; endproperty
  a_por: assert property (p_por) else $error("por low kept latch");
  property p_cause; code_error_pulse |-> $past(rx_code_valid, 2); endproperty
  a_cause: assert property (p_cause) else $error("pulse without group");
  property p_latch; code_error_pulse |-> code_error_latch; endproperty
  a_latch: assert property (p_latch) else $error("pulse without latch");
  property p_keep; code_error_latch && !signal_missing_flag |=> code_error_latch || signal_missing_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("latch dropped in sync");
  property p_quiet; quiet_r > 11'h3F0 |-> signal_missing_flag; endproperty
  a_quiet: assert property (p_quiet) else $error("silence kept sync");
  property p_mode; $stable(pins) [*8] |-> outs == pins; endproperty
  a_mode: assert property (p_mode) else $error("mode not applied");
  c_lock: cover property ($rose(link_synced_flag));
  c_err: cover property (code_error_pulse ##1 code_error_pulse);
  c_irq: cover property ($fell(irq));
endmodule
bind link_mode_and_error_status link_mode_monitor mon (.*);

// [testbench/board_model.sv]
// Board logic totalling error pulses of the block
`timescale 1ns/1ps
module board_model (
  input  wire logic        aclk,        // System clock
  input  wire logic        aresetn,     // Reset, active low
  input  wire logic        err_pulse,   // Error pulse from block
  output logic      [15:0] err_total_r  // Running error total
);
  logic [15:0] err_total_nxt;
  always_comb err_total_nxt = err_total_r + {15'h0, err_pulse};
  always_ff @(posedge aclk) err_total_r <= aresetn ? err_total_nxt : 16'h0;
endmodule

// [testbench/tb_link_mode_and_error_status.sv]
// Self-checking bench for the link mode and error status block
`timescale 1ns/1ps
module tb_link_mode_and_error_status;
  localparam logic [9:0] GOOD = 10'h2AA;
  localparam logic [9:0] BAD = 10'h00A;
  logic aclk = 0, aresetn = 0, power_on_reset_n = 1, rx_code_valid = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic signal_missing_flag, link_synced_flag, code_error_latch, code_error_pulse, symmetric_mode, irq;
  logic laser_adjust_mode, s_axi_arready, s_axi_rvalid;
  logic [9:0] rx_code = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, active_rate;
  logic [2:0] diag_mode;
  logic [1:0] line_format, s_axi_bresp, s_axi_rresp, rs;
  logic [10:0] mp = 11'h600;
  logic [15:0] err_total_r;
  logic q[$];
  int n_mismatch = 0, n_compared = 0, seed = 26, i;
  always #5 aclk = ~aclk;
  link_mode_and_error_status uut (.*, .format_hold(mp[10]), .laser_setup_n(mp[9]), .diag_mode_sel_2(mp[8]),
    .diag_mode_sel_1(mp[7]), .diag_mode_sel_0(mp[6]), .line_format_sel_1(mp[5]), .line_format_sel_0(mp[4]),
    .rate_sel_3(mp[3]), .rate_sel_2(mp[2]), .rate_sel_1(mp[1]), .rate_sel_0(mp[0]));
  board_model brd (.aclk(aclk), .aresetn(aresetn), .err_pulse(code_error_pulse), .err_total_r(err_total_r));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    chk("wait", 1, ok);
    if (!ok)
      complete_run;
  endtask
  task automatic send(input logic [9:0] c, input logic e);
    rx_code <= c;
    rx_code_valid <= 1;
    if (e)
      q.push_back(1);
    @(posedge aclk);
  endtask
  task automatic waitl;
    int k;
    for (k = 0; k < 40 && link_synced_flag !== 1; k++)
      @(posedge aclk);
    tmo(link_synced_flag === 1);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (k = 0; k < 30 && s_axi_bvalid !== 1; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    tmo(s_axi_bvalid === 1);
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (k = 0; k < 30 && s_axi_rvalid !== 1; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(s_axi_rvalid === 1);
  endtask
  // Each pulse cycle takes the oldest expected error
  always @(posedge aclk)
    if (code_error_pulse === 1)
    begin
      if (q.size() == 0)
        chk("pulse", 0, 1);
      else
        chk("latch", q.pop_front(), code_error_latch);
    end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 16; i++)
    begin
      rd = $random(seed);
      mp <= {rd[1:0], i[2:0], i[1:0], i[3:0]};
      repeat (8) @(posedge aclk);
      chk("mode", mp, {symmetric_mode, !laser_adjust_mode, diag_mode, line_format, active_rate});
    end
    send(BAD, 0);
    repeat (5) send(GOOD, 0);
    rx_code_valid <= 0;
    waitl;
    send(BAD, 1);
    send(GOOD, 0);
    send(BAD, 1);
    send(BAD, 1);
    rx_code_valid <= 0;
    repeat (4) @(posedge aclk);
    chk("count", 3, err_total_r);
    chk("irq", 0, irq);
    axr(link_mode_pkg::ADDR_STATE);
    chk("state", 32'h00010006, rd & 32'h00010007);
    axw(link_mode_pkg::ADDR_MASK, 32'h1);
    chk("bresp", link_mode_pkg::RESP_OKAY, rs);
    @(posedge aclk);
    chk("irq", 1, irq);
    axr(link_mode_pkg::ADDR_STATUS);
    chk("status", 32'h0000000D, rd);
    axw(link_mode_pkg::ADDR_STATUS, 32'hF);
    @(posedge aclk);
    chk("irq", 0, irq);
    axr(8'h10);
    chk("resp", link_mode_pkg::RESP_SLVERR, rs);
    chk("latch", 1, code_error_latch);
    power_on_reset_n <= 0;
    repeat (10) @(posedge aclk);
    chk("latch", 0, code_error_latch);
    power_on_reset_n <= 1;
    repeat (8) @(posedge aclk);
    repeat (6) send(GOOD, 0);
    rx_code_valid <= 0;
    waitl;
    repeat (1010) @(posedge aclk);
    chk("los", 1, signal_missing_flag);
    repeat (6) send(GOOD, 0);
    rx_code_valid <= 0;
    waitl;
    axw(link_mode_pkg::ADDR_CTRL, 32'h3);
    @(posedge aclk);
    chk("ctrl los", 1, signal_missing_flag);
    axr(link_mode_pkg::ADDR_CTRL);
    chk("ctrl", 32'h2, rd);
    chk("pending", 0, q.size());
    complete_run;
  end
endmodule
